/* File: rtl/fpt_fan_monitor.sv */
// Fan PWM generator and tachometer speed monitor with a plain register port.
`timescale 1ns/1ps
`default_nettype none
module fpt_fan_monitor
	import fpt_pkg::*;
#(
	parameter int ADDR_W = 8
)
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [7:0] reg_wr_data,
	input wire logic reg_wr_stb,
	input wire logic reg_rd_stb,
	output logic [7:0] reg_rd_data,
	input wire logic tach_in,
	output logic fan_drive_out,
	output logic irq
);

	// Fractional accumulator step: returns {tick, next value}.
	function automatic logic [17:0] acc_step(input logic [16:0] acc, input logic [16:0] step);
		logic [17:0] sum;
		sum = {1'b0, acc} + {1'b0, step};
		if (sum >= {1'b0, ACC_MOD})
			acc_step = {1'b1, 17'(sum - {1'b0, ACC_MOD})};
		else
			acc_step = {1'b0, sum[16:0]};
	endfunction

	// Mask of base-tick divider bits that must all be one for the selected rate.
	function automatic logic [2:0] mon_mask(input logic [1:0] sel);
		mon_mask = 3'((4'h1 << sel) - 4'h1);
	endfunction

	logic [7:0] duty_q;
	logic [7:0] prescale_q;
	logic [7:0] threshold_q;
	logic [7:0] speed_q;
	logic [1:0] clk_sel_q;
	logic filter_dis_q;
	logic irq_en_q;
	logic overflow_q;
	logic over_thresh_q;
	logic speed_ready_q;
	logic mon_en_q;
	logic drive_invert_q;
	logic [7:0] reg_rd_data_q;
	logic [16:0] acc_fast_q;
	logic [16:0] acc_slow_q;
	logic [16:0] acc_filt_q;
	logic [16:0] acc_mon_q;
	logic [17:0] fast_n;
	logic [17:0] slow_n;
	logic [17:0] filt_n;
	logic [17:0] mon_n;
	logic [6:0] div_q;
	logic [7:0] pwm_cnt_q;
	logic pwm_d;
	logic pwm_q;
	logic fan_drive_out_q;
	logic pwm_tick;
	logic src_tick;
	logic [2:0] mon_div_q;
	logic mon_tick;
	logic tach_s1_q;
	logic tach_s2_q;
	logic filt_q;
	logic [4:0] filt_cnt_q;
	logic tach_clean;
	logic tach_prev_q;
	logic tach_rise;
	fpt_mon_type mon_state_q;
	logic [7:0] upcnt_q;
	logic hold_q;
	logic capture;
	logic ovf_set;
	logic thresh_set;
	logic wr_cs;
	logic rd_speed;
	logic irq_q;

	// Tick generators: fractional accumulators give exact average rates from the 100 MHz clock.
	assign fast_n = acc_step(acc_fast_q, 17'(PWM_FAST_KHZ));
	assign slow_n = acc_step(acc_slow_q, 17'(PWM_SLOW_KHZ));
	assign filt_n = acc_step(acc_filt_q, 17'(FILTER_KHZ));
	assign mon_n = acc_step(acc_mon_q, 17'(MON_BASE_KHZ));

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_fast_q <= 17'h00000;
			acc_slow_q <= 17'h00000;
			acc_filt_q <= 17'h00000;
			acc_mon_q <= 17'h00000;
		end
		else
		begin
			acc_fast_q <= fast_n[16:0];
			acc_slow_q <= slow_n[16:0];
			acc_filt_q <= filt_n[16:0];
			acc_mon_q <= mon_n[16:0];
		end
	end

	// Prescaler: divides the selected source tick by prescale value plus one.
	assign src_tick = prescale_q[PS_CLK_SEL] ? slow_n[17] : fast_n[17];
	assign pwm_tick = src_tick && (div_q >= prescale_q[6:0]);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			div_q <= 7'h00;
		else if (pwm_tick)
			div_q <= 7'h00;
		else if (src_tick)
			div_q <= div_q + 7'h01;
	end

	// Free-running 8-bit PWM counter; the period is always 256 counter clocks.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			pwm_cnt_q <= 8'h00;
		else if (pwm_tick)
			pwm_cnt_q <= pwm_cnt_q + 8'h01;
	end

	// High while the count is below the duty value; FFh is forced high so no low slot remains.
	always_comb
	begin
		if (duty_q == DUTY_FULL)
			pwm_d = 1'b1;
		else
			pwm_d = (pwm_cnt_q < duty_q);
	end

	// Drive pin registered straight from the generator and the invert bit.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pwm_q <= 1'b0;
			fan_drive_out_q <= 1'b0;
		end
		else
		begin
			pwm_q <= pwm_d;
			fan_drive_out_q <= pwm_d ^ drive_invert_q;
		end
	end

	// Tach synchroniser; only the second stage is looked at by later logic.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tach_s1_q <= 1'b0;
			tach_s2_q <= 1'b0;
		end
		else
		begin
			tach_s1_q <= tach_in;
			tach_s2_q <= tach_s1_q;
		end
	end

	// Glitch filter: a new level must hold for a full run of 32 KHz samples before it is accepted.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			filt_q <= 1'b0;
			filt_cnt_q <= 5'h00;
		end
		else if (filt_n[17])
		begin
			if (tach_s2_q == filt_q)
				filt_cnt_q <= 5'h00;
			else if (filt_cnt_q >= 5'(FILTER_SAMPLES - 1))
			begin
				filt_q <= tach_s2_q;
				filt_cnt_q <= 5'h00;
			end
			else
				filt_cnt_q <= filt_cnt_q + 5'h01;
		end
	end

	assign tach_clean = filter_dis_q ? tach_s2_q : filt_q;
	assign tach_rise = tach_clean && !tach_prev_q;

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			tach_prev_q <= 1'b0;
		else
			tach_prev_q <= tach_clean;
	end

	// Monitor clock: 16 KHz base divided by 1, 2, 4 or 8 as the field selects.
	assign mon_tick = mon_n[17] && ((mon_div_q & mon_mask(clk_sel_q)) == mon_mask(clk_sel_q));

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			mon_div_q <= 3'h0;
		else if (mon_n[17])
			mon_div_q <= mon_div_q + 3'h1;
	end

	// Event terms shared by counter, speed register and status flags.
	assign wr_cs = reg_wr_stb && (reg_addr == ADDR_W'(OFS_CTRL_STATUS));
	assign rd_speed = reg_rd_stb && (reg_addr == ADDR_W'(OFS_SPEED));
	assign ovf_set = mon_en_q && !overflow_q && mon_tick && (upcnt_q == COUNT_MAX) && !tach_rise;
	assign capture = mon_en_q && tach_rise && (mon_state_q == FPT_MEASURE) && !hold_q && !overflow_q;
	assign thresh_set = capture && (upcnt_q > threshold_q);

	// Edge sequencing: the first edge after enabling only starts the interval.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			mon_state_q <= FPT_IDLE;
		else
		begin
			case (mon_state_q)
				FPT_IDLE:
					if (mon_en_q)
						mon_state_q <= FPT_ARMING;
				FPT_ARMING:
					if (!mon_en_q)
						mon_state_q <= FPT_IDLE;
					else if (tach_rise && !overflow_q)
						mon_state_q <= FPT_MEASURE;
				FPT_MEASURE:
					if (!mon_en_q)
						mon_state_q <= FPT_IDLE;
					else if (ovf_set)
						mon_state_q <= FPT_ARMING;
				default:
					mon_state_q <= FPT_IDLE;
			endcase
		end
	end

	// Up-counter; it stops while an overflow is pending so the stopped fan is not re-measured.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			upcnt_q <= 8'h00;
		else if (!mon_en_q)
			upcnt_q <= 8'h00;
		else if (tach_rise && !overflow_q && (mon_state_q != FPT_MEASURE || capture))
			upcnt_q <= 8'h00;
		else if (mon_tick && !overflow_q)
			upcnt_q <= upcnt_q + 8'h01;
	end

	// Speed reading register.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			speed_q <= RST_SPEED;
		else if (!mon_en_q)
			speed_q <= RST_SPEED;
		else if (ovf_set)
			speed_q <= RST_SPEED;
		else if (capture)
			speed_q <= upcnt_q;
	end

	// Hold keeps the interrupting value until the flag is cleared and then the value is read.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			hold_q <= 1'b0;
		else if (thresh_set)
			hold_q <= 1'b1;
		else if (rd_speed && !over_thresh_q)
			hold_q <= 1'b0;
	end

	// Status flags; a hardware set in the same cycle as a clear wins.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			overflow_q <= 1'b0;
			over_thresh_q <= 1'b0;
			speed_ready_q <= 1'b0;
		end
		else
		begin
			if (ovf_set)
				overflow_q <= 1'b1;
			else if (wr_cs && reg_wr_data[CS_OVERFLOW])
				overflow_q <= 1'b0;
			if (thresh_set)
				over_thresh_q <= 1'b1;
			else if (wr_cs && reg_wr_data[CS_OVER_THRESH])
				over_thresh_q <= 1'b0;
			if (!mon_en_q || ovf_set)
				speed_ready_q <= 1'b0;
			else if (capture)
				speed_ready_q <= 1'b1;
			else if (rd_speed)
				speed_ready_q <= 1'b0;
		end
	end

	// Software-written registers; the threshold is expected to stay put while monitoring.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			duty_q <= RST_DUTY;
			prescale_q <= RST_PRESCALE;
			threshold_q <= RST_THRESHOLD;
			clk_sel_q <= RST_CLK_SEL;
			filter_dis_q <= 1'b0;
			irq_en_q <= 1'b0;
			mon_en_q <= RST_CONFIG[CFG_MON_EN];
			drive_invert_q <= RST_CONFIG[CFG_DRIVE_INVERT];
		end
		else if (reg_wr_stb)
		begin
			if (reg_addr == ADDR_W'(OFS_DUTY))
				duty_q <= reg_wr_data;
			else if (reg_addr == ADDR_W'(OFS_PRESCALE))
				prescale_q <= reg_wr_data;
			else if (reg_addr == ADDR_W'(OFS_THRESHOLD))
				threshold_q <= reg_wr_data;
			else if (reg_addr == ADDR_W'(OFS_CTRL_STATUS))
			begin
				clk_sel_q <= reg_wr_data[CS_CLK_SEL_LO+:2];
				filter_dis_q <= reg_wr_data[CS_FILTER_DIS];
				irq_en_q <= reg_wr_data[CS_IRQ_EN];
			end
			else if (reg_addr == ADDR_W'(OFS_CONFIG))
			begin
				mon_en_q <= reg_wr_data[CFG_MON_EN];
				drive_invert_q <= reg_wr_data[CFG_DRIVE_INVERT];
			end
		end
	end

	// Read data stands in the cycle after the strobe only; unmapped offsets read zero.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			reg_rd_data_q <= 8'h00;
		else if (!reg_rd_stb)
			reg_rd_data_q <= 8'h00;
		else if (reg_addr == ADDR_W'(OFS_DUTY))
			reg_rd_data_q <= duty_q;
		else if (reg_addr == ADDR_W'(OFS_PRESCALE))
			reg_rd_data_q <= prescale_q;
		else if (reg_addr == ADDR_W'(OFS_THRESHOLD))
			reg_rd_data_q <= threshold_q;
		else if (reg_addr == ADDR_W'(OFS_SPEED))
			reg_rd_data_q <= speed_q;
		else if (reg_addr == ADDR_W'(OFS_CTRL_STATUS))
			reg_rd_data_q <= {1'b0, clk_sel_q, filter_dis_q, irq_en_q, overflow_q, over_thresh_q, speed_ready_q};
		else if (reg_addr == ADDR_W'(OFS_CONFIG))
			reg_rd_data_q <= {6'h00, drive_invert_q, mon_en_q};
		else
			reg_rd_data_q <= 8'h00;
	end

	// Interrupt request registered from the enable and both alarm flags.
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
			irq_q <= 1'b0;
		else
			irq_q <= irq_en_q && (overflow_q || over_thresh_q);
	end

	assign reg_rd_data = reg_rd_data_q;
	assign fan_drive_out = fan_drive_out_q;
	assign irq = irq_q;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_capture;
		capture ##1 speed_ready_q;
	endsequence

	property p_duty_zero_low;
		(duty_q == 8'h00) |=> !pwm_q;
	endproperty
	a_duty_zero_low: assert property (p_duty_zero_low) else $error("Duty zero did not hold output low.");

	property p_duty_full_high;
		(duty_q == 8'hFF) |=> pwm_q;
	endproperty
	a_duty_full_high: assert property (p_duty_full_high) else $error("Duty FFh did not hold output high.");

	property p_pwm_compare;
		(duty_q != 8'hFF) |=> (pwm_q == ($past(pwm_cnt_q) < $past(duty_q)));
	endproperty
	a_pwm_compare: assert property (p_pwm_compare) else $error("Generator output disagrees with count and duty.");

	property p_drive_invert;
		##1 (fan_drive_out == (pwm_q ^ $past(drive_invert_q)));
	endproperty
	a_drive_invert: assert property (p_drive_invert) else $error("Drive pin does not follow generator and invert bit.");

	property p_disabled_zero;
		!mon_en_q |=> (upcnt_q == 8'h00) && (speed_q == 8'h00);
	endproperty
	a_disabled_zero: assert property (p_disabled_zero) else $error("Counter or speed not zero while disabled.");

	property p_capture;
		capture && !ovf_set |-> s_capture ##0 (speed_q == $past(upcnt_q)) && (upcnt_q <= 8'h01);
	endproperty
	a_capture: assert property (p_capture) else $error("Capture did not load speed, zero counter and set ready.");

	property p_read_clears_ready;
		rd_speed && !capture |=> !speed_ready_q;
	endproperty
	a_read_clears_ready: assert property (p_read_clears_ready) else $error("Speed read did not clear ready.");

	property p_thresh_flag;
		capture && (upcnt_q > threshold_q) |=> over_thresh_q ##1 (irq == irq_en_q);
	endproperty
	a_thresh_flag: assert property (p_thresh_flag) else $error("Value above threshold did not set the flag.");

	property p_hold_speed;
		mon_en_q && hold_q && !ovf_set |=> (speed_q == $past(speed_q));
	endproperty
	a_hold_speed: assert property (p_hold_speed) else $error("Speed changed while held by threshold flag.");

	property p_overflow;
		ovf_set |=> overflow_q && (speed_q == 8'h00) && !speed_ready_q;
	endproperty
	a_overflow: assert property (p_overflow) else $error("Counter overflow not handled.");

	property p_w1c;
		wr_cs && reg_wr_data[CS_OVERFLOW] && !ovf_set |=> !overflow_q;
	endproperty
	a_w1c: assert property (p_w1c) else $error("Writing one did not clear overflow.");

	property p_irq;
		##1 (irq == $past(irq_en_q && (overflow_q || over_thresh_q)));
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt does not follow enable and flags.");

endmodule
`default_nettype wire

/* File: rtl/fpt_pkg.sv */
// Package of offsets, field positions, reset values and timing counts for the fan PWM and tach monitor.
package fpt_pkg;
	// Register offsets on the plain register port.
	localparam logic [7:0] OFS_DUTY = 8'h00;
	localparam logic [7:0] OFS_PRESCALE = 8'h01;
	localparam logic [7:0] OFS_THRESHOLD = 8'h02;
	localparam logic [7:0] OFS_SPEED = 8'h03;
	localparam logic [7:0] OFS_CTRL_STATUS = 8'h04;
	localparam logic [7:0] OFS_CONFIG = 8'h05;
	// Field positions of the control and status register.
	localparam int CS_CLK_SEL_LO = 5;
	localparam int CS_FILTER_DIS = 4;
	localparam int CS_IRQ_EN = 3;
	localparam int CS_OVERFLOW = 2;
	localparam int CS_OVER_THRESH = 1;
	localparam int CS_SPEED_READY = 0;
	// Field positions of the prescale register and of the configuration register.
	localparam int PS_CLK_SEL = 7;
	localparam int CFG_MON_EN = 0;
	localparam int CFG_DRIVE_INVERT = 1;
	// Reset values.
	localparam logic [7:0] RST_DUTY = 8'hFF;
	localparam logic [7:0] RST_PRESCALE = 8'h00;
	localparam logic [7:0] RST_THRESHOLD = 8'hFF;
	localparam logic [7:0] RST_SPEED = 8'h00;
	localparam logic [1:0] RST_CLK_SEL = 2'h1;
	localparam logic [7:0] RST_CONFIG = 8'h00;
	// Rates in KHz, used by fractional tick accumulators on the system clock.
	localparam int CLK_KHZ = 100000;
	localparam int PWM_FAST_KHZ = 24000;
	localparam int PWM_SLOW_KHZ = 200;
	localparam int FILTER_KHZ = 32;
	localparam int MON_BASE_KHZ = 16;
	localparam logic [16:0] ACC_MOD = 17'(CLK_KHZ);
	// Shortest tach pulse that the filter lets through, and its length in filter samples.
	localparam int FILTER_MIN_US = 750;
	localparam int FILTER_SAMPLES = (FILTER_MIN_US * FILTER_KHZ + 999) / 1000;
	// Duty value that keeps the generator high for the whole period.
	localparam logic [7:0] DUTY_FULL = 8'hFF;
	localparam logic [7:0] COUNT_MAX = 8'hFF;
	// Monitor states.
	typedef enum logic [1:0] {FPT_IDLE, FPT_ARMING, FPT_MEASURE} fpt_mon_type;
endpackage

/* File: tb/fpt_fan_model.sv */
// Behavioural cooling fan: a tach pulse source and a meter of the PWM drive it receives.
`timescale 1ns/1ps
`default_nettype none
module fpt_fan_model
#(
	parameter int TACH_HIGH = 30
)
(
	input wire logic ref_clk,
	input wire logic fan_drive,
	output logic tach_out
);
	// The tach line rests low between pulses, as an idle fan output does.
	initial tach_out = 1'b0;

	// One tach pulse; it is long enough to pass the two-flop synchroniser.
	task automatic pulse();
		@(posedge ref_clk);
		tach_out <= 1'b1;
		repeat (TACH_HIGH) @(posedge ref_clk);
		tach_out <= 1'b0;
	endtask

	// Counts the clocks in which the drive is high over a window of win clocks.
	task automatic measure(input int win, output int hi);
		hi = 0;
		repeat (win)
		begin
			@(posedge ref_clk);
			if (fan_drive === 1'b1)
				hi++;
		end
	endtask
endmodule
`default_nettype wire

/* File: tb/tb_fpt_fan_monitor.sv */
// Self-checking testbench for the fan PWM generator and tach speed monitor.
`timescale 1ns/1ps
`default_nettype none
module tb_fpt_fan_monitor
	import fpt_pkg::*;
;
	// Monitor ticks at 16 KHz are this many system clocks apart.
	localparam int TICK = 6250;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wr_data = 8'h00;
	logic reg_wr_stb = 1'b0;
	logic reg_rd_stb = 1'b0;
	logic [7:0] reg_rd_data;
	logic tach_in;
	logic fan_drive_out;
	logic irq;
	int mismatches = 0;
	int n_tests = 0;

	// A 100 MHz system clock.
	always #5 ref_clk = ~ref_clk;

	fpt_fan_monitor fpt_fan_monitor_i (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.reg_addr(reg_addr),
		.reg_wr_data(reg_wr_data),
		.reg_wr_stb(reg_wr_stb),
		.reg_rd_stb(reg_rd_stb),
		.reg_rd_data(reg_rd_data),
		.tach_in(tach_in),
		.fan_drive_out(fan_drive_out),
		.irq(irq)
	);

	fpt_fan_model fpt_fan_model_i (
		.ref_clk(ref_clk),
		.fan_drive(fan_drive_out),
		.tach_out(tach_in)
	);

	task automatic fail(input string msg);
		mismatches++;
		$display("[FAIL] %0t %s", $time, msg);
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
		n_tests++;
		if (got !== exp)
			fail($sformatf("%s got %h expected %h", what, got, exp));
	endtask

	task automatic chk_cnt(input int got, input int lo, input int hi, input string what);
		n_tests++;
		if (got < lo || got > hi)
			fail($sformatf("%s got %0d expected %0d..%0d", what, got, lo, hi));
	endtask

	task automatic wait_cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask

	// Write strobe is held for exactly one edge; the slave never stalls.
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wr_data <= d;
		reg_wr_stb <= 1'b1;
		@(posedge ref_clk);
		reg_wr_stb <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so they are taken just after that edge.
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd_stb <= 1'b1;
		@(posedge ref_clk);
		reg_rd_stb <= 1'b0;
		#1;
		d = reg_rd_data;
	endtask

	task automatic test_regs();
		logic [7:0] ofs [7] = '{OFS_DUTY, OFS_PRESCALE, OFS_THRESHOLD, OFS_SPEED, OFS_CTRL_STATUS, OFS_CONFIG, 8'h07};
		logic [7:0] rst [7] = '{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h20, 8'h00, 8'h00};
		logic [7:0] d;
		for (int i = 0; i < 7; i++)
		begin
			reg_rd(ofs[i], d);
			chk8(d, rst[i], "reset value");
		end
		reg_wr(OFS_SPEED, 8'h55);
		reg_rd(OFS_SPEED, d);
		chk8(d, 8'h00, "speed write ignored");
		for (int k = 0; k < 4; k++)
		begin
			reg_wr(OFS_CTRL_STATUS, {1'b1, 2'(k), 5'h00});
			reg_rd(OFS_CTRL_STATUS, d);
			chk8(d, {1'b0, 2'(k), 5'h00}, "clock field");
		end
		$display("test regs done");
	endtask

	// High time over a window of whole PWM periods; the 24 MHz tick jitters by one clock.
	task automatic test_pwm(input logic [7:0] duty, input logic inv, input logic [7:0] ps, input int win);
		int hi;
		int exp;
		int tol;
		reg_wr(OFS_PRESCALE, ps);
		reg_wr(OFS_DUTY, duty);
		reg_wr(OFS_CONFIG, {6'h00, inv, 1'b0});
		wait_cyc(1100 * (int'(ps) + 1));
		fpt_fan_model_i.measure(win, hi);
		exp = (duty == DUTY_FULL) ? win : (int'(duty) * win) / 256;
		tol = (duty == 8'h00 || duty == DUTY_FULL) ? 0 : 6;
		if (inv)
			exp = win - exp;
		chk_cnt(hi, exp - tol, exp + tol, "pwm high clocks");
		$display("test pwm duty %h invert %b done", duty, inv);
	endtask

	// Two tach edges two ticks apart; a capture equal to the threshold raises no flag.
	task automatic test_capture();
		logic [7:0] d;
		reg_wr(OFS_THRESHOLD, 8'h02);
		reg_wr(OFS_CTRL_STATUS, 8'h10);
		reg_wr(OFS_CONFIG, 8'h01);
		fpt_fan_model_i.pulse();
		// Rises are 2*TICK+1 clocks apart, so exactly two monitor ticks fall strictly between the two rises.
		wait_cyc(2 * TICK - 30);
		fpt_fan_model_i.pulse();
		wait_cyc(20);
		reg_rd(OFS_CTRL_STATUS, d);
		chk8(d, 8'h11, "ready without over flag");
		chk8({7'h00, irq}, 8'h00, "irq idle");
		reg_rd(OFS_SPEED, d);
		chk8(d, 8'h02, "captured interval");
		reg_rd(OFS_CTRL_STATUS, d);
		chk8(d, 8'h10, "ready cleared by read");
		reg_wr(OFS_CONFIG, 8'h00);
		reg_rd(OFS_SPEED, d);
		chk8(d, 8'h00, "speed zero when disabled");
		$display("test capture done");
	endtask

	// Over-threshold capture freezes the speed until a one is written and the speed is read.
	task automatic test_threshold();
		logic [7:0] d;
		reg_wr(OFS_THRESHOLD, 8'h01);
		reg_wr(OFS_CTRL_STATUS, 8'h18);
		reg_wr(OFS_CONFIG, 8'h01);
		fpt_fan_model_i.pulse();
		wait_cyc(2 * TICK - 30);
		fpt_fan_model_i.pulse();
		wait_cyc(20);
		reg_rd(OFS_CTRL_STATUS, d);
		chk8(d, 8'h1B, "over threshold set");
		chk8({7'h00, irq}, 8'h01, "irq on over threshold");
		reg_rd(OFS_SPEED, d);
		chk8(d, 8'h02, "value above threshold");
		wait_cyc(TICK - 60);
		fpt_fan_model_i.pulse();
		wait_cyc(20);
		reg_rd(OFS_SPEED, d);
		chk8(d, 8'h02, "speed frozen");
		reg_wr(OFS_CTRL_STATUS, 8'h18);
		reg_rd(OFS_CTRL_STATUS, d);
		chk8(d, 8'h1A, "write zero keeps flag");
		reg_wr(OFS_CTRL_STATUS, 8'h1A);
		reg_rd(OFS_CTRL_STATUS, d);
		chk8(d, 8'h18, "write one clears flag");
		wait_cyc(3);
		chk8({7'h00, irq}, 8'h00, "irq dropped");
		reg_rd(OFS_SPEED, d);
		wait_cyc(TICK);
		fpt_fan_model_i.pulse();
		wait_cyc(20);
		reg_rd(OFS_CTRL_STATUS, d);
		chk8(d & 8'h01, 8'h01, "captures resumed");
		reg_wr(OFS_CONFIG, 8'h00);
		reg_wr(OFS_CTRL_STATUS, 8'h06);
		$display("test threshold done");
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
		begin
			$display("bench passed");
		end
		else
		begin
			$display("bench failed");
		end
		$finish;
	endtask

	// Main sequence: reset for four clocks, then the scenarios in turn.
	initial
	begin
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		test_regs();
		test_pwm(8'h00, 1'b0, 8'h00, 3200);
		test_pwm(8'hFF, 1'b0, 8'h00, 3200);
		test_pwm(8'h01, 1'b0, 8'h00, 3200);
		test_pwm(8'hFE, 1'b0, 8'h00, 3200);
		test_pwm(8'h40, 1'b1, 8'h00, 3200);
		test_pwm(8'hFF, 1'b1, 8'h00, 3200);
		test_pwm(8'h40, 1'b0, 8'h01, 6400);
		test_capture();
		test_threshold();
		test_done();
	end

	// Watchdog well beyond the planned run length, so a hang ends in the same verdict.
	initial
	begin
		repeat (95000) @(posedge ref_clk);
		fail("watchdog expired");
		test_done();
	end
endmodule
`default_nettype wire
